// ### fspg_top.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
// How it works
// - The wheel count saturates inside minus 127 to plus 127.
// - Surface quality reports the frame's feature count, clamped to at most 128.
// - The exposure registers hold the 16-bit shutter-open cycle count of the last image.
// - The brightest-pixel register holds the last image's maximum in bits 6:0, bit 7 zero.
// - The darkest-pixel register holds the last image's minimum in bits 6:0, bit 7 zero.
// - All 361 pixels sum into 17 bits and bits 15:8 of that sum are reported.
// - The grabber captures at most one pixel per frame.
// - Reading a valid grab sets bit 7, advances the pixel index and rearms the grabber.
// - Any grab write resets the index and arms capture of pixel 0 on the next image.
// - Pixels number 0 to 360, down each 19-pixel column before the next column.
module fspg_top (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Register port
	input wire logic [fspg_pkg::ADDR_W-1:0] i_addr,
	input wire logic [fspg_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [fspg_pkg::DATA_W-1:0] o_rdata,
	// Image pipeline, same clock
	input wire logic i_frame_start,
	input wire logic i_frame_end,
	input wire logic i_pix_valid,
	input wire logic [fspg_pkg::PIX_W-1:0] i_pix_data,
	input wire logic i_shutter_open,
	input wire logic [fspg_pkg::DATA_W-1:0] i_feature_count,
	// Wheel quadrature pins
	input wire logic i_wheel_a,
	input wire logic i_wheel_b
);
	import fspg_pkg::*;

	// ----------------------------------------------------------------
	// Pixel stream
	// ----------------------------------------------------------------
	fspg_pix_if pix_bus ();

	logic [IDX_W-1:0] pix_count;

	assign pix_bus.frame_start = i_frame_start;
	assign pix_bus.frame_end = i_frame_end;
	assign pix_bus.pix_valid = i_pix_valid;
	assign pix_bus.pix_data = i_pix_data;
	assign pix_bus.pix_index = pix_count;

	// Arrival order is the numbering order, column by column
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pix_count <= PIX_FIRST;
		end else if (i_frame_start) begin
			pix_count <= PIX_FIRST;
		end else if (i_pix_valid && pix_count != PIX_LAST) begin
			pix_count <= pix_count + 9'h001;
		end
	end

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	logic [PIX_W-1:0] brightest;
	logic [PIX_W-1:0] darkest;
	logic [SUM_W-1:0] pixel_sum;
	logic [EXP_W-1:0] exposure;
	logic grab_valid;
	logic [PIX_W-1:0] grab_data;
	logic rd_grab;
	logic wr_grab;

	assign rd_grab = i_rd && (i_addr == REG_GRAB);
	assign wr_grab = i_wr && (i_addr == REG_GRAB);

	fspg_frame_stats u_stats (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.pix(pix_bus.sink),
		.i_shutter_open(i_shutter_open),
		.o_brightest(brightest),
		.o_darkest(darkest),
		.o_pixel_sum(pixel_sum),
		.o_exposure(exposure)
	);

	fspg_grabber u_grab (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.pix(pix_bus.sink),
		.i_grab_wr(wr_grab),
		.i_grab_rd(rd_grab),
		.o_grab_valid(grab_valid),
		.o_grab_data(grab_data)
	);

	// ----------------------------------------------------------------
	// Surface quality
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] surface_quality;

	// Feature count can glitch high on noisy frames, so clamp it
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			surface_quality <= RESET_ZERO;
		end else if (i_frame_end) begin
			surface_quality <= (i_feature_count > SURFACE_QUALITY_MAX) ?
				SURFACE_QUALITY_MAX : i_feature_count;
		end
	end

	// ----------------------------------------------------------------
	// Wheel count
	// ----------------------------------------------------------------
	logic wheel_a_meta;
	logic wheel_a_sync;
	logic wheel_a_prev;
	logic wheel_b_meta;
	logic wheel_b_sync;
	logic wheel_step;
	logic wheel_down;
	logic rd_wheel;
	logic signed [DATA_W-1:0] wheel_count;
	logic signed [DATA_W-1:0] next_wheel_count;

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wheel_a_meta <= 1'b0;
			wheel_a_sync <= 1'b0;
			wheel_b_meta <= 1'b0;
			wheel_b_sync <= 1'b0;
			wheel_a_prev <= 1'b0;
		end else begin
			wheel_a_meta <= i_wheel_a;
			wheel_a_sync <= wheel_a_meta;
			wheel_b_meta <= i_wheel_b;
			wheel_b_sync <= wheel_b_meta;
			wheel_a_prev <= wheel_a_sync;
		end
	end

	// One count per rising edge of phase A, sign from phase B
	assign wheel_step = wheel_a_sync && !wheel_a_prev;
	assign wheel_down = wheel_b_sync;
	assign rd_wheel = i_rd && (i_addr == REG_WHEEL);

	// A read clears the count, but a step in the same cycle survives
	always_comb begin
		next_wheel_count = rd_wheel ? 8'sh00 : wheel_count;
		if (wheel_step && !wheel_down && next_wheel_count < WHEEL_MAX) begin
			next_wheel_count = next_wheel_count + 8'sh01;
		end else if (wheel_step && wheel_down && next_wheel_count > WHEEL_MIN) begin
			next_wheel_count = next_wheel_count - 8'sh01;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wheel_count <= 8'sh00;
		end else begin
			wheel_count <= next_wheel_count;
		end
	end

	// ----------------------------------------------------------------
	// Exposure pair coherence
	// ----------------------------------------------------------------
	logic exp_lock;
	logic [DATA_W-1:0] exp_low_shadow;
	logic rd_exp_high;
	logic rd_exp_low;

	assign rd_exp_high = i_rd && (i_addr == REG_EXPOSURE_HIGH);
	assign rd_exp_low = i_rd && (i_addr == REG_EXPOSURE_LOW);

	// A new image may land between the two reads; the shadow keeps the pair whole
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			exp_lock <= 1'b0;
			exp_low_shadow <= EXPOSURE_RESET[DATA_W-1:0];
		end else if (rd_exp_high) begin
			exp_lock <= 1'b1;
			exp_low_shadow <= exposure[DATA_W-1:0];
		end else if (rd_exp_low) begin
			exp_lock <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] next_rdata;

	always_comb begin
		case (i_addr)
			REG_WHEEL: next_rdata = wheel_count;
			REG_SURFACE_QUALITY: next_rdata = surface_quality;
			REG_EXPOSURE_HIGH: next_rdata = exposure[EXP_W-1:DATA_W];
			REG_EXPOSURE_LOW: begin
				next_rdata = exp_lock ? exp_low_shadow : exposure[DATA_W-1:0];
			end
			REG_BRIGHTEST: next_rdata = {1'b0, brightest};
			REG_PIXEL_SUM: next_rdata = pixel_sum[SUM_FIELD_MSB:SUM_FIELD_LSB];
			REG_DARKEST: next_rdata = {1'b0, darkest};
			REG_GRAB: next_rdata = {grab_valid, grab_data};
			default: next_rdata = RESET_ZERO;
		endcase
	end

	// Data stands only in the cycle after the read strobe
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= RESET_ZERO;
		end else if (i_rd) begin
			o_rdata <= next_rdata;
		end else begin
			o_rdata <= RESET_ZERO;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);

	sequence s_high_read;
		i_rd && i_addr == REG_EXPOSURE_HIGH;
	endsequence

	sequence s_low_read_locked;
		exp_lock && i_rd && i_addr == REG_EXPOSURE_LOW;
	endsequence

	sequence s_wheel_up;
		wheel_step && !wheel_down && !rd_wheel && wheel_count < WHEEL_MAX;
	endsequence

	sequence s_wheel_down;
		wheel_step && wheel_down && !rd_wheel && wheel_count > WHEEL_MIN;
	endsequence

	a_wheel_range: assert property (
		wheel_count >= WHEEL_MIN && wheel_count <= WHEEL_MAX
	) else $error("wheel count left its range");

	a_wheel_read_clear: assert property (
		(rd_wheel && !wheel_step) |=> wheel_count == 8'sh00
	) else $error("wheel count not cleared by read");

	a_quality_clamp: assert property (
		i_frame_end |=> surface_quality == (($past(i_feature_count) > SURFACE_QUALITY_MAX) ?
			SURFACE_QUALITY_MAX : $past(i_feature_count))
	) else $error("surface quality not clamped to 128");

	a_exp_pair_hold: assert property (
		s_low_read_locked
			|=> o_rdata == $past(exp_low_shadow)
	) else $error("exposure low byte not held after high read");

	a_exp_high_lock: assert property (
		s_high_read |=> exp_lock && exp_low_shadow == $past(exposure[DATA_W-1:0])
	) else $error("high read did not capture the low byte");

	a_max_bit_zero: assert property (
		(i_rd && i_addr == REG_BRIGHTEST) |=> !o_rdata[GRAB_VALID_BIT]
			&& o_rdata[PIX_W-1:0] == $past(brightest)
	) else $error("brightest pixel readback wrong");

	a_min_bit_zero: assert property (
		(i_rd && i_addr == REG_DARKEST) |=> !o_rdata[GRAB_VALID_BIT]
			&& o_rdata[PIX_W-1:0] == $past(darkest)
	) else $error("darkest pixel readback wrong");

	a_sum_upper_field: assert property (
		(i_rd && i_addr == REG_PIXEL_SUM) |=> o_rdata == $past(pixel_sum[SUM_FIELD_MSB:SUM_FIELD_LSB])
	) else $error("pixel sum field wrong");

	a_grab_valid_bit: assert property (
		(rd_grab && grab_valid) |=> o_rdata[GRAB_VALID_BIT]
	) else $error("valid grab read without bit 7");

	a_rdata_idle_zero: assert property (
		!i_rd |=> o_rdata == RESET_ZERO
	) else $error("read data outside the read answer cycle");

	a_exp_shadow_hold: assert property (
		(exp_lock && !rd_exp_high) |=> $stable(exp_low_shadow)
	) else $error("held exposure low byte changed");

	a_quality_max: assert property (
		surface_quality <= SURFACE_QUALITY_MAX
	) else $error("surface quality above 128");

	a_quality_hold: assert property (
		!i_frame_end |=> $stable(surface_quality)
	) else $error("surface quality changed outside frame end");

	a_exp_high_field: assert property (
		rd_exp_high
			|=> o_rdata == $past(exposure[EXP_W-1:DATA_W])
	) else $error("exposure high byte readback wrong");

	a_exp_low_live: assert property (
		(rd_exp_low && !exp_lock)
			|=> o_rdata == $past(exposure[DATA_W-1:0])
	) else $error("unlocked exposure low byte readback wrong");

	a_exp_low_release: assert property (
		rd_exp_low |=> !exp_lock
	) else $error("low byte read did not release the hold");

	a_wheel_step_up: assert property (
		s_wheel_up |=> wheel_count == $past(wheel_count) + 8'sh01
	) else $error("wheel count missed an upward step");

	a_wheel_step_down: assert property (
		s_wheel_down |=> wheel_count == $past(wheel_count) - 8'sh01
	) else $error("wheel count missed a downward step");

	a_grab_read_data: assert property (
		rd_grab |=> o_rdata[PIX_W-1:0] == $past(grab_data)
	) else $error("grab readback data wrong");

	a_grab_clear_bit: assert property (
		(rd_grab && !grab_valid) |=> !o_rdata[GRAB_VALID_BIT]
	) else $error("grab read flagged valid without a pixel");

	a_pix_index_cap: assert property (
		pix_count <= PIX_LAST
	) else $error("pixel index beyond the last pixel");

	a_pix_index_step: assert property (
		(i_pix_valid && !i_frame_start && pix_count != PIX_LAST)
			|=> pix_count == $past(pix_count) + 9'h001
	) else $error("pixel index did not follow arrival order");

	a_unmapped_zero: assert property (
		(i_rd && i_addr > REG_GRAB) |=> o_rdata == RESET_ZERO
	) else $error("unmapped read returned data");
endmodule

// ### fspg_pkg.sv
package fspg_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_WHEEL = 8'h06;
	localparam logic [7:0] REG_SURFACE_QUALITY = 8'h07;
	localparam logic [7:0] REG_EXPOSURE_HIGH = 8'h08;
	localparam logic [7:0] REG_EXPOSURE_LOW = 8'h09;
	localparam logic [7:0] REG_BRIGHTEST = 8'h0a;
	localparam logic [7:0] REG_PIXEL_SUM = 8'h0b;
	localparam logic [7:0] REG_DARKEST = 8'h0c;
	localparam logic [7:0] REG_GRAB = 8'h0d;

	// ----------------------------------------------------------------
	// Field layouts and widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int PIX_W = 7;
	localparam int IDX_W = 9;
	localparam int SUM_W = 17;
	localparam int SUM_FIELD_LSB = 8;
	localparam int SUM_FIELD_MSB = 15;
	localparam int EXP_W = 16;
	localparam int GRAB_VALID_BIT = 7;

	// ----------------------------------------------------------------
	// Reset values and limits
	// ----------------------------------------------------------------
	localparam logic [DATA_W-1:0] RESET_ZERO = 8'h00;
	localparam logic [EXP_W-1:0] EXPOSURE_RESET = 16'h0064;
	localparam logic [DATA_W-1:0] SURFACE_QUALITY_MAX = 8'h80;
	localparam logic signed [DATA_W-1:0] WHEEL_MAX = 8'sh7f;
	localparam logic signed [DATA_W-1:0] WHEEL_MIN = -8'sh7f;
	localparam logic [PIX_W-1:0] PIX_FULL_SCALE = 7'h7f;
	localparam logic [IDX_W-1:0] PIX_FIRST = 9'h000;
	localparam logic [IDX_W-1:0] PIX_LAST = 9'h168;

	// ----------------------------------------------------------------
	// Grabber states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		GRAB_IDLE = 4'b0001,
		GRAB_WAIT = 4'b0010,
		GRAB_ARMED = 4'b0100,
		GRAB_FULL = 4'b1000
	} fspg_grab_state_t;

endpackage

// ### fspg_pix_if.sv
`timescale 1ns/10ps
interface fspg_pix_if;
	import fspg_pkg::*;
	logic frame_start;
	logic frame_end;
	logic pix_valid;
	logic [PIX_W-1:0] pix_data;
	logic [IDX_W-1:0] pix_index;

	modport src (
		output frame_start,
		output frame_end,
		output pix_valid,
		output pix_data,
		output pix_index
	);
	modport sink (
		input frame_start,
		input frame_end,
		input pix_valid,
		input pix_data,
		input pix_index
	);
endinterface

// ### fspg_frame_stats.sv
`timescale 1ns/10ps
module fspg_frame_stats (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Pixel stream and shutter
	fspg_pix_if.sink pix,
	input wire logic i_shutter_open,
	// Results of the last finished image
	output logic [fspg_pkg::PIX_W-1:0] o_brightest,
	output logic [fspg_pkg::PIX_W-1:0] o_darkest,
	output logic [fspg_pkg::SUM_W-1:0] o_pixel_sum,
	output logic [fspg_pkg::EXP_W-1:0] o_exposure
);
	import fspg_pkg::*;

	logic [PIX_W-1:0] run_max;
	logic [PIX_W-1:0] run_min;
	logic [SUM_W-1:0] run_sum;
	logic [EXP_W-1:0] run_exp;

	// Running figures restart on each image
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			run_max <= '0;
			run_min <= PIX_FULL_SCALE;
			run_sum <= '0;
		end else if (pix.frame_start) begin
			run_max <= '0;
			run_min <= PIX_FULL_SCALE;
			run_sum <= '0;
		end else if (pix.pix_valid) begin
			if (pix.pix_data > run_max) begin
				run_max <= pix.pix_data;
			end
			if (pix.pix_data < run_min) begin
				run_min <= pix.pix_data;
			end
			// 361 pixels of at most 127 cannot overflow 17 bits
			run_sum <= run_sum + {{(SUM_W-PIX_W){1'b0}}, pix.pix_data};
		end
	end

	// Shutter time in main-clock cycles, saturating rather than wrapping
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			run_exp <= '0;
		end else if (pix.frame_start) begin
			run_exp <= '0;
		end else if (i_shutter_open && run_exp != {EXP_W{1'b1}}) begin
			run_exp <= run_exp + 16'h0001;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_brightest <= '0;
			o_darkest <= '0;
			o_pixel_sum <= '0;
			o_exposure <= EXPOSURE_RESET;
		end else if (pix.frame_end) begin
			o_brightest <= run_max;
			o_darkest <= run_min;
			o_pixel_sum <= run_sum;
			o_exposure <= run_exp;
		end
	end

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);

	a_stats_latch_frame: assert property (
		pix.frame_end |=> o_pixel_sum == $past(run_sum) && o_brightest == $past(run_max)
	) else $error("frame figures not latched at frame end");

	a_stats_exp_hold: assert property (
		!pix.frame_end |=> $stable(o_exposure)
	) else $error("exposure result changed outside frame end");
endmodule

// ### fspg_grabber.sv
`timescale 1ns/10ps
module fspg_grabber (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Pixel stream
	fspg_pix_if.sink pix,
	// Register side effects
	input wire logic i_grab_wr,
	input wire logic i_grab_rd,
	// Holding register
	output logic o_grab_valid,
	output logic [fspg_pkg::PIX_W-1:0] o_grab_data
);
	import fspg_pkg::*;

	fspg_grab_state_t state;
	logic [IDX_W-1:0] target;
	logic capture;

	assign capture = (state == GRAB_ARMED) && pix.pix_valid && (pix.pix_index == target);

	// A write beats a capture or a read in the same cycle
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= GRAB_IDLE;
		end else if (i_grab_wr) begin
			state <= GRAB_WAIT;
		end else begin
			case (state)
				GRAB_WAIT: begin
					// Waiting for a whole image keeps one pixel per frame
					if (pix.frame_start) begin
						state <= GRAB_ARMED;
					end
				end
				GRAB_ARMED: begin
					if (capture) begin
						state <= GRAB_FULL;
					end
				end
				GRAB_FULL: begin
					if (i_grab_rd) begin
						state <= GRAB_WAIT;
					end
				end
				default: state <= state;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			target <= PIX_FIRST;
		end else if (i_grab_wr) begin
			target <= PIX_FIRST;
		end else if (state == GRAB_FULL && i_grab_rd) begin
			target <= (target == PIX_LAST) ? PIX_FIRST : target + 9'h001;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_grab_data <= '0;
		end else if (capture && !i_grab_wr) begin
			o_grab_data <= pix.pix_data;
		end
	end

	assign o_grab_valid = (state == GRAB_FULL);

	// Helper: captures since the last frame start
	logic [1:0] caps_in_frame;
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			caps_in_frame <= '0;
		end else if (pix.frame_start) begin
			caps_in_frame <= '0;
		end else if (capture && caps_in_frame != 2'h3) begin
			caps_in_frame <= caps_in_frame + 2'h1;
		end
	end

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);

	a_grab_one_frame: assert property (
		caps_in_frame <= 2'h1
	) else $error("grabber took more than one pixel in a frame");

	a_grab_read_advance: assert property (
		(i_grab_rd && state == GRAB_FULL && !i_grab_wr) |=> state == GRAB_WAIT
			&& target == (($past(target) == PIX_LAST) ? PIX_FIRST : $past(target) + 9'h001)
	) else $error("valid read did not advance and rearm");

	a_grab_write_rearm: assert property (
		i_grab_wr |=> state == GRAB_WAIT && target == PIX_FIRST
	) else $error("write did not reset the grabber to pixel 0");

	a_grab_capture_data: assert property (
		(capture && !i_grab_wr) |=> o_grab_valid && o_grab_data == $past(pix.pix_data)
			&& $past(pix.pix_index) == target
	) else $error("captured pixel or index mismatch");
endmodule

// ### fspg_host_model.sv
`timescale 1ns/10ps
module fspg_host_model (
	// Clock
	input wire logic i_sys_clk,
	// Register port, host side
	output logic [fspg_pkg::ADDR_W-1:0] o_addr,
	output logic [fspg_pkg::DATA_W-1:0] o_wdata,
	output logic o_wr,
	output logic o_rd
);
	import fspg_pkg::*;

	initial begin
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end

	// One-cycle strobe; the address is inverted afterwards so a stale value never looks valid
	task automatic access(input logic [ADDR_W-1:0] a, input logic is_wr);
		@(posedge i_sys_clk);
		o_addr <= a;
		o_wdata <= 8'($urandom);
		o_wr <= is_wr;
		o_rd <= ~is_wr;
		@(posedge i_sys_clk);
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		o_addr <= ~a;
	endtask

	// High byte first, so the low byte belongs to the same image
	task automatic read_exposure();
		access(REG_EXPOSURE_HIGH, 1'b0);
		access(REG_EXPOSURE_LOW, 1'b0);
	endtask

	// Average pixel as software derives it from the sum register
	function automatic real average_pixel(input logic [DATA_W-1:0] accum);
		return accum / 1.41;
	endfunction
endmodule

// ### tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import fspg_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic i_sys_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic wr;
	logic rd;
	logic frame_start = 1'b0;
	logic frame_end = 1'b0;
	logic pix_valid = 1'b0;
	logic [PIX_W-1:0] pix_data = 7'h00;
	logic shutter = 1'b0;
	logic [DATA_W-1:0] feature = 8'h00;
	logic wheel_a = 1'b0;
	logic wheel_b = 1'b0;
	logic rd_seen = 1'b0;
	logic [DATA_W-1:0] exp_q[$];
	logic [PIX_W-1:0] pix_mem[0:360];
	logic [PIX_W-1:0] mx;
	logic [PIX_W-1:0] mn;
	logic [SUM_W-1:0] sum;
	logic [EXP_W-1:0] shut;
	logic [DATA_W-1:0] fq;
	logic [DATA_W-1:0] fc_tab[5] = '{8'h00, 8'h80, 8'h81, 8'hff, 8'h37};
	int errors = 0;
	int check_count = 0;
	int cycles = 0;

	always #12.5 i_sys_clk = ~i_sys_clk;

	fspg_top i_dut (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_addr(addr),
		.i_wdata(wdata),
		.i_wr(wr),
		.i_rd(rd),
		.o_rdata(rdata),
		.i_frame_start(frame_start),
		.i_frame_end(frame_end),
		.i_pix_valid(pix_valid),
		.i_pix_data(pix_data),
		.i_shutter_open(shutter),
		.i_feature_count(feature),
		.i_wheel_a(wheel_a),
		.i_wheel_b(wheel_b)
	);

	fspg_host_model i_host (
		.i_sys_clk(i_sys_clk),
		.o_addr(addr),
		.o_wdata(wdata),
		.o_wr(wr),
		.o_rd(rd)
	);

	// ----------------------------------------------------------------
	// Read data monitor: zero unless the previous edge took a read
	// ----------------------------------------------------------------
	always @(posedge i_sys_clk) rd_seen <= rd;

	always @(negedge i_sys_clk) begin
		logic [DATA_W-1:0] e;
		e = 8'h00;
		if (rd_seen && exp_q.size() > 0) begin
			e = exp_q.pop_front();
		end
		check_count++;
		if (rdata !== e) begin
			errors++;
			$display("ERROR %0t: read data %h, expected %h", $time, rdata, e);
		end
	end

	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 95000) begin
			errors++;
			$display("ERROR %0t: run did not finish in time", $time);
			end_of_test();
		end
	end

	task automatic end_of_test();
		if (errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Stimulus tasks
	// ----------------------------------------------------------------
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		exp_q.push_back(e);
		i_host.access(a, 1'b0);
	endtask

	// Start pulse, shutter open for nshut edges, npix pixels, end pulse
	task automatic frame(input int npix, input int nshut, input logic [DATA_W-1:0] fc);
		logic [PIX_W-1:0] v;
		@(posedge i_sys_clk);
		frame_start <= 1'b1;
		feature <= fc;
		fq = fc;
		shut = EXP_W'(nshut);
		mx = 7'h00;
		mn = 7'h7f;
		sum = '0;
		@(posedge i_sys_clk);
		frame_start <= 1'b0;
		shutter <= 1'b1;
		repeat (nshut) @(posedge i_sys_clk);
		shutter <= 1'b0;
		for (int i = 0; i < npix; i++) begin
			v = 7'($urandom);
			pix_valid <= 1'b1;
			pix_data <= v;
			pix_mem[i] = v;
			mx = (v > mx) ? v : mx;
			mn = (v < mn) ? v : mn;
			sum = sum + SUM_W'(v);
			@(posedge i_sys_clk);
		end
		pix_valid <= 1'b0;
		pix_data <= ~pix_data;
		frame_end <= 1'b1;
		@(posedge i_sys_clk);
		frame_end <= 1'b0;
	endtask

	task automatic check_stats();
		real r;
		rd_chk(REG_SURFACE_QUALITY, (fq > SURFACE_QUALITY_MAX) ? SURFACE_QUALITY_MAX : fq);
		rd_chk(REG_BRIGHTEST, {1'b0, mx});
		rd_chk(REG_DARKEST, {1'b0, mn});
		rd_chk(REG_PIXEL_SUM, sum[15:8]);
		exp_q.push_back(shut[15:8]);
		exp_q.push_back(shut[7:0]);
		i_host.read_exposure();
		r = i_host.average_pixel(sum[15:8]) - real'(sum) / 361.0;
		check_count++;
		if (r > 1.0 || r < -1.0) begin
			errors++;
			$display("ERROR %0t: average pixel estimate off by %f", $time, r);
		end
	endtask

	// Wheel pin A pulses; direction set by pin B level
	task automatic wheel_steps(input int n, input logic dir);
		wheel_b <= dir;
		repeat (n) begin
			@(posedge i_sys_clk);
			wheel_a <= 1'b1;
			repeat (3) @(posedge i_sys_clk);
			wheel_a <= 1'b0;
			repeat (3) @(posedge i_sys_clk);
		end
		repeat (6) @(posedge i_sys_clk);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h5d850e5d));
		repeat (12) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		// Read-only write ignored; reset values; 0x0e is unmapped
		i_host.access(REG_SURFACE_QUALITY, 1'b1);
		for (int i = 0; i < 9; i++) begin
			rd_chk(8'(6 + i), (i == 3) ? 8'h64 : 8'h00);
		end
		// Full and empty frames, feature counts around the clamp
		for (int i = 0; i < 5; i++) begin
			frame((i == 4) ? 0 : 361, 1 + $urandom_range(0, 700), fc_tab[i]);
			i_host.access(8'(7 + $urandom_range(0, 5)), 1'b1);
			check_stats();
		end
		// Low byte frozen by the high-byte read across a new image
		frame(19, 300, 8'h10);
		rd_chk(REG_EXPOSURE_HIGH, 8'h01);
		frame(19, 520, 8'h10);
		rd_chk(REG_EXPOSURE_LOW, 8'h2c);
		rd_chk(REG_EXPOSURE_LOW, 8'h08);
		rd_chk(REG_EXPOSURE_HIGH, 8'h02);
		// Whole image upload, then the index wraps to pixel 0
		i_host.access(REG_GRAB, 1'b1);
		for (int k = 0; k < 362; k++) begin
			frame(k % 361 + 1, 1, 8'h00);
			rd_chk(REG_GRAB, {1'b1, pix_mem[k % 361]});
			rd_chk(REG_GRAB, {1'b0, pix_mem[k % 361]});
		end
		i_host.access(REG_GRAB, 1'b1);
		frame(3, 1, 8'h00);
		rd_chk(REG_GRAB, {1'b1, pix_mem[0]});
		// Wheel saturates both ways and clears on read
		wheel_steps(130, 1'b0);
		rd_chk(REG_WHEEL, 8'h7f);
		rd_chk(REG_WHEEL, 8'h00);
		wheel_steps(130, 1'b1);
		rd_chk(REG_WHEEL, 8'h81);
		repeat (3) @(posedge i_sys_clk);
		end_of_test();
	end
endmodule
